// *** hdl/isr_pkg.sv ***
// Shared constants for the instrument status reporting block
package isr_pkg;

  // Command codes presented on the command port
  localparam logic [3:0] ISR_CMD_CLS   = 4'h0;
  localparam logic [3:0] ISR_CMD_OPC   = 4'h1;
  localparam logic [3:0] ISR_CMD_ESR_Q = 4'h2;
  localparam logic [3:0] ISR_CMD_ESE   = 4'h3;
  localparam logic [3:0] ISR_CMD_ESE_Q = 4'h4;
  localparam logic [3:0] ISR_CMD_STB_Q = 4'h5;
  localparam logic [3:0] ISR_CMD_SRE   = 4'h6;
  localparam logic [3:0] ISR_CMD_SRE_Q = 4'h7;
  localparam logic [3:0] ISR_CMD_TST_Q = 4'h8;
  localparam logic [3:0] ISR_CMD_OPC_Q = 4'h9;
  localparam logic [3:0] ISR_CMD_WAI   = 4'hA;
  localparam logic [3:0] ISR_CMD_RST   = 4'hB;

  // Event status bit positions
  localparam int ISR_ES_OPC = 0;
  localparam int ISR_ES_QYE = 2;
  localparam int ISR_ES_DDE = 3;
  localparam int ISR_ES_EXE = 4;
  localparam int ISR_ES_CME = 5;
  localparam int ISR_ES_PON = 7;

  // Bits of the event status register that can ever be set
  localparam logic [7:0] ISR_ES_USED_MASK = 8'hBD;

  // Status byte bit positions
  localparam int ISR_SB_MAV = 4;
  localparam int ISR_SB_ESB = 5;
  localparam int ISR_SB_MSS = 6;

  // Reset values
  localparam logic [7:0] ISR_ESR_RESET = 8'h00;
  localparam logic [7:0] ISR_ESE_RESET = 8'h00;
  localparam logic [7:0] ISR_SRE_RESET = 8'h00;
  localparam logic [7:0] ISR_STB_RESET = 8'h00;

  // Self-test and operation-complete query replies
  localparam logic [7:0] ISR_TST_PASS = 8'h00;
  localparam logic [7:0] ISR_TST_FAIL = 8'h01;
  localparam logic [7:0] ISR_OPC_ONE  = 8'h01;

endpackage

// *** hdl/isr_event_if.sv ***
// Connection between the command logic and the event status register
`timescale 1ns/1ps
interface isr_event_if;
  logic [7:0] set;
  logic       clr;
  logic [7:0] q;

  modport owner (input set, input clr, output q);
  modport user  (output set, output clr, input q);
endinterface

// *** hdl/isr_event_reg.sv ***
// Sticky event status register with set-over-clear
`timescale 1ns/1ps
module isr_event_reg
  import isr_pkg::*;
(
  input  wire logic   clock,
  input  wire logic   rst_n,
  isr_event_if.owner  ev
);

  typedef struct packed {
    logic [7:0] bits;
  } isr_er_s;

  isr_er_s st_reg;
  isr_er_s st_next;

  always_comb begin
    st_next = st_reg;
    // Clear first, then new events, so an event in the clear cycle survives
    st_next.bits = ((ev.clr ? ISR_ESR_RESET : st_reg.bits) | ev.set) & ISR_ES_USED_MASK;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '{bits: ISR_ESR_RESET};
    end else begin
      st_reg <= st_next;
    end
  end

  assign ev.q = st_reg.bits;

endmodule

// *** hdl/isr_status_core.sv ***
// Status reporting core: event, enable, status byte and command handling
`timescale 1ns/1ps
// Notes on behaviour
// - Event status query returns the event register
// - Armed completion sets bit 0 after test
// - Event bits 1 and 6 always read zero
// - Query error sets event bit 2
// - Device error sets event bit 3
// - Execution error sets event bit 4
// - Command error sets event bit 5
// - Power-on sets event bit 7
// - Event enable mask is stored and read back
// - Status byte query returns the status byte
// - Status byte bit 4 means message waiting
// - Status byte bit 5 summarises enabled events
// - Status byte bit 6 is request service
// - Service enable mask is stored and read back
// - Clear status zeroes the event register
// - Clear status drops any pending service request
// - Self-test replies 00H pass, 01H memory fail
// - Empty or lost output queue is query error
// - Syntax error or unknown header is command error
module isr_status_core
  import isr_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       cmd_valid,
  input  wire logic [3:0] cmd_code,
  input  wire logic [7:0] cmd_data,
  input  wire logic       test_done_ok,
  input  wire logic       queue_read_empty,
  input  wire logic       queue_data_lost,
  input  wire logic       device_fault,
  input  wire logic       exec_fault,
  input  wire logic       syntax_fault,
  input  wire logic       msg_available,
  input  wire logic       nvm_test_fail,
  output logic            resp_valid,
  output logic [7:0]      resp_data,
  output logic [7:0]      status_byte,
  output logic            service_request
);

  typedef struct packed {
    logic [7:0] ese;
    logic [7:0] sre;
    logic [7:0] stb;
    logic       opc_armed;
    logic       pon_done;
    logic       srq;
    logic       resp_valid;
    logic [7:0] resp_data;
  } isr_core_s;

  logic      rst_meta_reg;
  logic      rst_sync_reg;
  isr_core_s st_reg;
  isr_core_s st_next;
  logic      is_cls;
  logic      known_cmd;
  logic      esb;
  logic      mss;
  logic [7:0] sb_base;

  isr_event_if ev ();

  isr_event_reg u_event_reg (
    .clock (clock),
    .rst_n (rst_sync_reg),
    .ev    (ev)
  );

  // Reset release through two flops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  always_comb begin
    is_cls    = cmd_valid && (cmd_code == ISR_CMD_CLS);
    known_cmd = (cmd_code <= ISR_CMD_RST);
    ev.clr    = is_cls;
    ev.set    = 8'h00;
    ev.set[ISR_ES_OPC] = st_reg.opc_armed && test_done_ok;
    ev.set[ISR_ES_QYE] = queue_read_empty || queue_data_lost;
    ev.set[ISR_ES_DDE] = device_fault;
    ev.set[ISR_ES_EXE] = exec_fault;
    ev.set[ISR_ES_CME] = syntax_fault || (cmd_valid && !known_cmd);
    ev.set[ISR_ES_PON] = !st_reg.pon_done;
  end

  always_comb begin
    st_next            = st_reg;
    st_next.resp_valid = 1'b0;
    st_next.pon_done   = 1'b1;
    if (st_reg.opc_armed && test_done_ok) begin
      st_next.opc_armed = 1'b0;
    end
    if (cmd_valid) begin
      unique case (cmd_code)
        ISR_CMD_CLS: begin
          st_next.opc_armed = 1'b0;
        end
        ISR_CMD_OPC: begin
          st_next.opc_armed = 1'b1;
        end
        ISR_CMD_ESR_Q: begin
          st_next.resp_valid = 1'b1;
          st_next.resp_data  = ev.q;
        end
        ISR_CMD_ESE: begin
          st_next.ese = cmd_data;
        end
        ISR_CMD_ESE_Q: begin
          st_next.resp_valid = 1'b1;
          st_next.resp_data  = st_reg.ese;
        end
        ISR_CMD_STB_Q: begin
          st_next.resp_valid = 1'b1;
          st_next.resp_data  = st_reg.stb;
        end
        ISR_CMD_SRE: begin
          st_next.sre = cmd_data;
        end
        ISR_CMD_SRE_Q: begin
          st_next.resp_valid = 1'b1;
          st_next.resp_data  = st_reg.sre;
        end
        ISR_CMD_TST_Q: begin
          st_next.resp_valid = 1'b1;
          st_next.resp_data  = nvm_test_fail ? ISR_TST_FAIL : ISR_TST_PASS;
        end
        ISR_CMD_OPC_Q: begin
          st_next.resp_valid = 1'b1;
          st_next.resp_data  = ISR_OPC_ONE;
        end
        ISR_CMD_WAI, ISR_CMD_RST: begin
          st_next.resp_valid = 1'b0;
        end
        default: begin
          st_next.resp_valid = 1'b0;
        end
      endcase
    end
    // Summary bits; a clear forces ESB and the service request to zero at once
    esb     = (|(ev.q & st_reg.ese)) && !is_cls;
    sb_base = 8'h00;
    sb_base[ISR_SB_MAV] = msg_available;
    sb_base[ISR_SB_ESB] = esb;
    mss     = |(sb_base & st_reg.sre);
    st_next.stb = sb_base;
    st_next.stb[ISR_SB_MSS] = mss;
    st_next.srq = mss && !is_cls;
  end

  always_ff @(posedge clock or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      st_reg <= '{ese: ISR_ESE_RESET, sre: ISR_SRE_RESET, stb: ISR_STB_RESET,
                  opc_armed: 1'b0, pon_done: 1'b0, srq: 1'b0,
                  resp_valid: 1'b0, resp_data: 8'h00};
    end else begin
      st_reg <= st_next;
    end
  end

  assign resp_valid      = st_reg.resp_valid;
  assign resp_data       = st_reg.resp_data;
  assign status_byte     = st_reg.stb;
  assign service_request = st_reg.srq;

  chk_esr_query_data: assert property (@(posedge clock) disable iff (!rst_sync_reg)
    (cmd_valid && cmd_code == ISR_CMD_ESR_Q) |=> (resp_valid && resp_data == $past(ev.q)))
    else $error("event status query reply wrong");

  chk_opc_bit_set: assert property (@(posedge clock) disable iff (!rst_sync_reg)
    (st_reg.opc_armed && test_done_ok) |=> ev.q[ISR_ES_OPC])
    else $error("operation complete bit not set");

  chk_unused_bits_zero: assert property (@(posedge clock) disable iff (!rst_sync_reg)
    (ev.q[1] == 1'b0) && (ev.q[6] == 1'b0))
    else $error("unused event bit nonzero");

  chk_query_err_set: assert property (@(posedge clock) disable iff (!rst_sync_reg)
    (queue_read_empty || queue_data_lost) |=> ev.q[ISR_ES_QYE])
    else $error("query error bit not set");

  chk_device_err_set: assert property (@(posedge clock) disable iff (!rst_sync_reg)
    device_fault |=> ev.q[ISR_ES_DDE])
    else $error("device error bit not set");

  chk_exec_err_set: assert property (@(posedge clock) disable iff (!rst_sync_reg)
    exec_fault |=> ev.q[ISR_ES_EXE])
    else $error("execution error bit not set");

  chk_cmd_err_set: assert property (@(posedge clock) disable iff (!rst_sync_reg)
    (syntax_fault || (cmd_valid && cmd_code > ISR_CMD_RST)) |=> ev.q[ISR_ES_CME])
    else $error("command error bit not set");

  chk_power_on_set: assert property (@(posedge clock) disable iff (!rst_sync_reg)
    !st_reg.pon_done |=> ev.q[ISR_ES_PON])
    else $error("power-on bit not set");

  chk_ese_write_back: assert property (@(posedge clock) disable iff (!rst_sync_reg)
    (cmd_valid && cmd_code == ISR_CMD_ESE) |=> (st_reg.ese == $past(cmd_data)))
    else $error("event enable store wrong");

  chk_stb_query_data: assert property (@(posedge clock) disable iff (!rst_sync_reg)
    (cmd_valid && cmd_code == ISR_CMD_STB_Q) |=> (resp_valid && resp_data == $past(status_byte)))
    else $error("status byte reply wrong");

  chk_mav_follows: assert property (@(posedge clock) disable iff (!rst_sync_reg)
    1'b1 |=> (status_byte[ISR_SB_MAV] == $past(msg_available)))
    else $error("message available bit wrong");

  chk_srq_mss_tie: assert property (@(posedge clock) disable iff (!rst_sync_reg)
    service_request |-> status_byte[ISR_SB_MSS])
    else $error("service request without summary");

  chk_sre_write_back: assert property (@(posedge clock) disable iff (!rst_sync_reg)
    (cmd_valid && cmd_code == ISR_CMD_SRE) |=> (st_reg.sre == $past(cmd_data)))
    else $error("service enable store wrong");

  chk_cls_clears_esr: assert property (@(posedge clock) disable iff (!rst_sync_reg)
    (is_cls && ev.set == 8'h00) |=> (ev.q == 8'h00))
    else $error("clear status left event bits");

  chk_cls_drops_srq: assert property (@(posedge clock) disable iff (!rst_sync_reg)
    is_cls |=> (!service_request && !status_byte[ISR_SB_ESB]))
    else $error("clear status left service request");

  chk_selftest_reply: assert property (@(posedge clock) disable iff (!rst_sync_reg)
    (cmd_valid && cmd_code == ISR_CMD_TST_Q)
      |=> (resp_valid && resp_data == ($past(nvm_test_fail) ? ISR_TST_FAIL : ISR_TST_PASS)))
    else $error("self-test reply wrong");

  chk_esb_summary: assert property (@(posedge clock) disable iff (!rst_sync_reg)
    !is_cls |=> (status_byte[ISR_SB_ESB] == $past(|(ev.q & st_reg.ese))))
    else $error("event summary bit wrong");

endmodule

// *** verification/isr_ctl_model.sv ***
// Controller model that issues status commands and collects replies
`timescale 1ns/1ps
module isr_ctl_model
  import isr_pkg::*;
(
  input  wire logic       clock,
  output logic            cmd_valid,
  output logic [3:0]      cmd_code,
  output logic [7:0]      cmd_data,
  input  wire logic       resp_valid,
  input  wire logic [7:0] resp_data
);
  logic [7:0] reply;
  logic       got;

  initial begin
    cmd_valid = 1'b0;
    cmd_code  = 4'h0;
    cmd_data  = 8'h00;
    reply     = 8'h00;
    got       = 1'b0;
  end

  // One command per call; after the strobe the lines carry inverted junk
  task automatic send(input logic [3:0] code, input logic [7:0] data);
    @(posedge clock);
    #1;
    cmd_valid = 1'b1;
    cmd_code  = code;
    cmd_data  = data;
    @(posedge clock);
    #1;
    cmd_valid = 1'b0;
    cmd_code  = ~code;
    cmd_data  = ~data;
    got       = 1'b0;
    for (int i = 0; i < 3; i++) begin
      if (!got && resp_valid === 1'b1) begin
        got   = 1'b1;
        reply = resp_data;
      end
      if (!got) begin
        @(posedge clock);
        #1;
      end
    end
  endtask
endmodule

// *** verification/instrument_status_reporting_tb_top.sv ***
// Bench for the status reporting core against an integer model
`timescale 1ns/1ps
module instrument_status_reporting_tb_top;
  import isr_pkg::*;
  logic       clock = 1'b0;
  logic       rst_n = 1'b0;
  logic       cmd_valid;
  logic [3:0] cmd_code;
  logic [7:0] cmd_data;
  logic [5:0] evt = 6'h00;
  logic       msg_available = 1'b0;
  logic       nvm_test_fail = 1'b0;
  logic       resp_valid;
  logic [7:0] resp_data;
  logic [7:0] status_byte;
  logic       service_request;
  logic [7:0] m_stb;
  int         err_total = 0;
  int         tests_run = 0;
  int         seed = 32'hCE7B91E6;
  int         m_esr;
  int         m_ese;
  int         m_sre;
  int         m_arm;
  int         v;

  always #2.5 clock = ~clock;

  isr_ctl_model ctl (.clock(clock), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data),
    .resp_valid(resp_valid), .resp_data(resp_data));

  isr_status_core uut (.clock(clock), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_data(cmd_data), .test_done_ok(evt[5]), .queue_read_empty(evt[4]), .queue_data_lost(evt[3]),
    .device_fault(evt[2]), .exec_fault(evt[1]), .syntax_fault(evt[0]), .msg_available(msg_available),
    .nvm_test_fail(nvm_test_fail), .resp_valid(resp_valid), .resp_data(resp_data),
    .status_byte(status_byte), .service_request(service_request));

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmd(input logic [3:0] c, input logic [7:0] d);
    ctl.send(c, d);
    case (c)
      ISR_CMD_CLS: begin
        m_esr = 0;
        m_arm = 0;
      end
      ISR_CMD_OPC: m_arm = 1;
      ISR_CMD_ESE: m_ese = d;
      ISR_CMD_SRE: m_sre = d;
      default: if (c > 4'hB) m_esr |= 8'h20;
    endcase
  endtask

  task automatic qry(input logic [3:0] c, input logic [7:0] exp);
    cmd(c, 8'h00);
    cmp({7'h00, ctl.got}, 8'h01);
    cmp(ctl.reply, exp);
  endtask

  // Bit order of evt: done, empty read, lost data, device, execution, syntax
  task automatic pulse(input logic [5:0] m);
    @(posedge clock);
    #1 evt = m;
    @(posedge clock);
    #1 evt = 6'h00;
    m_esr |= {m[0], m[1], m[2], m[4] | m[3], 1'b0, m[5] & (m_arm != 0)};
    if (m[5]) m_arm = 0;
  endtask

  task automatic chk_stb;
    logic esb;
    logic mss;
    repeat (4) @(posedge clock);
    #1;
    esb   = |(m_esr[7:0] & m_ese[7:0]);
    mss   = |({esb, msg_available} & m_sre[5:4]);
    m_stb = {1'b0, mss, esb, msg_available, 4'h0};
    cmp(status_byte, m_stb);
    cmp({7'h00, service_request}, {7'h00, mss});
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #400000;
    err_total++;
    test_done;
  end

  initial begin
    m_esr = 8'h80;
    m_ese = 0;
    m_sre = 0;
    m_arm = 0;
    repeat (5) @(posedge clock);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clock);
    qry(ISR_CMD_ESR_Q, 8'h80);
    chk_stb;
    for (int i = 0; i < 24; i++) begin
      v = $random(seed);
      cmd(ISR_CMD_ESE, v[7:0]);
      cmd(ISR_CMD_SRE, v[15:8]);
      qry(ISR_CMD_ESE_Q, v[7:0]);
      qry(ISR_CMD_SRE_Q, v[15:8]);
      msg_available = v[16];
      nvm_test_fail = v[17];
      if (i % 3 == 0) cmd(ISR_CMD_OPC, 8'h00);
      if (i % 8 == 7) cmd(ISR_CMD_CLS, 8'h00);
      if (i % 5 == 4) cmd(4'hC + 4'(i % 4), 8'h00);
      pulse(6'h01 << (i % 6));
      qry(ISR_CMD_ESR_Q, m_esr[7:0]);
      chk_stb;
      qry(ISR_CMD_STB_Q, m_stb);
      qry(ISR_CMD_TST_Q, {7'h00, v[17]});
      qry(ISR_CMD_OPC_Q, ISR_OPC_ONE);
      cmd(v[18] ? ISR_CMD_WAI : ISR_CMD_RST, 8'h00);
    end
    test_done;
  end
endmodule
